// File: common/gpio_port_pkg.sv
// Register map, field layouts and reset values of the dual GPIO port block.
// Assumes a 32-bit Avalon-MM slave with word addresses in byte units.
package gpio_port_pkg;
    localparam int          ADDR_W           = 6;
    localparam int          DATA_W           = 32;
    localparam int          PORT_W           = 8;
    // Register byte offsets
    localparam logic [5:0]  OFF_A_PIN_DATA   = 6'h00;
    localparam logic [5:0]  OFF_A_DIRECTION  = 6'h04;
    localparam logic [5:0]  OFF_A_PULLUP     = 6'h08;
    localparam logic [5:0]  OFF_A_ANALOG     = 6'h0c;
    localparam logic [5:0]  OFF_OPTION       = 6'h10;
    localparam logic [5:0]  OFF_B_PIN_DATA   = 6'h14;
    localparam logic [5:0]  OFF_B_DIRECTION  = 6'h18;
    localparam logic [5:0]  OFF_B_PULLUP     = 6'h1c;
    localparam logic [5:0]  OFF_B_ANALOG     = 6'h20;
    localparam logic [5:0]  OFF_B_CHANGE_IRQ = 6'h24;
    // Implemented bit masks
    localparam logic [7:0]  A_DATA_MASK      = 8'hef;
    localparam logic [7:0]  A_DIR_MASK       = 8'hcf;
    localparam logic [7:0]  A_PULLUP_MASK    = 8'h2f;
    localparam logic [7:0]  A_ANALOG_MASK    = 8'h0f;
    localparam logic [7:0]  B_DATA_MASK      = 8'hf3;
    localparam logic [7:0]  B_PULLUP_MASK    = 8'hf2;
    localparam logic [7:0]  B_ANALOG_MASK    = 8'hf2;
    localparam logic [7:0]  B_IRQ_MASK       = 8'hf7;
    // Reset values
    localparam logic [7:0]  A_DIR_RST        = 8'hef;
    localparam logic [7:0]  A_PULLUP_RST     = 8'h2f;
    localparam logic [7:0]  A_ANALOG_RST     = 8'h0f;
    localparam logic [7:0]  B_DIR_RST        = 8'hf3;
    localparam logic [7:0]  B_PULLUP_RST     = 8'hf2;
    localparam logic [7:0]  B_ANALOG_RST     = 8'hf2;
    localparam logic [7:0]  OPTION_RST       = 8'hff;
    localparam logic [7:0]  LATCH_RST        = 8'h00;
    localparam logic [7:0]  IRQ_EN_RST       = 8'h00;
    // Field positions
    localparam int          A_INPUT_ONLY_BIT = 5;
    localparam int          A_OPENDRAIN_BIT  = 7;
    localparam int          B_OPENDRAIN_BIT  = 0;
    localparam int          GLOBAL_PU_BIT    = 7;
    localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;
endpackage : gpio_port_pkg

// File: hdl/dual_gpio_port_control.sv
// Two 8-bit GPIO ports with direction, pull-up, analog select and latches.
// Assumes pin inputs synchronous to i_core_clk; pads resolve the enables.
// Function
// - Direction one disables driver, zero drives
// - Input-only pin direction reads one always
// - Unimplemented bit positions read as zero
// - Port A pull-up needs global, input, bit, digital
// - Master-clear use also enables pin5 pull-up
// - Analog bits select analog or digital use
// - Analog disables digital input, pull-up, change irq
// - Data read returns pins; write sets latch
// - Analog pins read zero digitally
// - Analog select leaves digital output alone
// - Enabled peripheral takes its pin
// - Driving needs direction clear; read shows pin
// - Port B change enables, cleared at reset
// - Port B pull-ups off while pin outputs
// - Reset disables all pull-ups globally except the pin5 master-clear pull-up
// - Port B analog bits reset to analog
// - B0 open-drain shared, B1 shares DAC
// - Port A config bits reset to one
// - Highest priority enabled function takes pin
// - Bit 7 of port A is open-drain
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dual_gpio_port_control
(
    // Clock and reset
    input  wire logic                               i_core_clk,
    input  wire logic                               i_rst,
    // Avalon-MM slave
    input  wire logic [gpio_port_pkg::ADDR_W-1:0]   i_avs_address,
    input  wire logic                               i_avs_read,
    input  wire logic                               i_avs_write,
    input  wire logic [gpio_port_pkg::DATA_W-1:0]   i_avs_writedata,
    input  wire logic [3:0]                         i_avs_byteenable,
    output logic      [gpio_port_pkg::DATA_W-1:0]   o_avs_readdata,
    output logic                                    o_avs_waitrequest,
    // Configuration word: pin5 used as master clear
    input  wire logic                               i_master_clear_input_en,
    // Peripheral outputs, enable per pin (one peripheral per pin)
    input  wire logic [7:0]                         i_a_periph_en,
    input  wire logic [7:0]                         i_a_periph_out,
    input  wire logic [7:0]                         i_b_periph_en,
    input  wire logic [7:0]                         i_b_periph_out,
    // Port A pads
    input  wire logic [7:0]                         i_a_pin,
    output logic      [7:0]                         o_a_pin,
    output logic      [7:0]                         o_a_pin_oe,
    output logic      [7:0]                         o_a_pullup,
    // Port B pads
    input  wire logic [7:0]                         i_b_pin,
    output logic      [7:0]                         o_b_pin,
    output logic      [7:0]                         o_b_pin_oe,
    output logic      [7:0]                         o_b_pullup,
    // Analog mode and change-interrupt enables seen by other blocks
    output logic      [7:0]                         o_a_analog_mode,
    output logic      [7:0]                         o_b_analog_mode,
    output logic      [7:0]                         o_b_change_irq_en
);
    import gpio_port_pkg::*;

    logic [7:0] a_latch_q, b_latch_q;
    logic [7:0] a_dir_q, b_dir_q;
    logic [7:0] a_pu_q, b_pu_q;
    logic [7:0] a_ana_q, b_ana_q;
    logic [7:0] option_q;
    logic [7:0] b_irq_q;
    logic       ack_q;
    logic [7:0] a_in_dig, b_in_dig;
    logic [7:0] wr_byte;
    logic       wr_lane;
    logic       wr_hit;

    // Writes land only on the accept edge, when waitrequest is low
    assign wr_byte = i_avs_writedata[7:0];
    assign wr_lane = i_avs_byteenable[0];
    assign wr_hit  = i_avs_write && ack_q && wr_lane;

    assign a_in_dig = i_a_pin & ~a_ana_q & A_DATA_MASK;
    assign b_in_dig = i_b_pin & ~b_ana_q & B_DATA_MASK;

    // One wait state: waitrequest drops in the cycle after the request
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            ack_q <= 1'b0;
        else
            ack_q <= (i_avs_read || i_avs_write) && !ack_q;
    end

    // Registered waitrequest: high when idle, low for the accept cycle
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_avs_waitrequest <= 1'b1;
        else
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_q);
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            a_latch_q <= LATCH_RST;
            b_latch_q <= LATCH_RST;
        end
        else if (wr_hit && i_avs_address == OFF_A_PIN_DATA)
            a_latch_q <= wr_byte & A_DATA_MASK;
        else if (wr_hit && i_avs_address == OFF_B_PIN_DATA)
            b_latch_q <= wr_byte & B_DATA_MASK;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            a_dir_q <= A_DIR_RST;
            a_pu_q  <= A_PULLUP_RST;
            a_ana_q <= A_ANALOG_RST;
        end
        else if (wr_hit)
        begin
            if (i_avs_address == OFF_A_DIRECTION)
                a_dir_q <= (wr_byte & A_DIR_MASK) | (8'h01 << A_INPUT_ONLY_BIT);
            if (i_avs_address == OFF_A_PULLUP)
                a_pu_q <= wr_byte & A_PULLUP_MASK;
            if (i_avs_address == OFF_A_ANALOG)
                a_ana_q <= wr_byte & A_ANALOG_MASK;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            b_dir_q  <= B_DIR_RST;
            b_pu_q   <= B_PULLUP_RST;
            b_ana_q  <= B_ANALOG_RST;
            b_irq_q  <= IRQ_EN_RST;
            option_q <= OPTION_RST;
        end
        else if (wr_hit)
        begin
            if (i_avs_address == OFF_B_DIRECTION)
                b_dir_q <= wr_byte & B_DATA_MASK;
            if (i_avs_address == OFF_B_PULLUP)
                b_pu_q <= wr_byte & B_PULLUP_MASK;
            if (i_avs_address == OFF_B_ANALOG)
                b_ana_q <= wr_byte & B_ANALOG_MASK;
            if (i_avs_address == OFF_B_CHANGE_IRQ)
                b_irq_q <= wr_byte & B_IRQ_MASK;
            if (i_avs_address == OFF_OPTION)
                option_q <= wr_byte;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_avs_readdata <= UNMAPPED_DATA;
        else if (i_avs_read && !ack_q)
        begin
            case (i_avs_address)
                OFF_A_PIN_DATA:   o_avs_readdata <= {24'h000000, a_in_dig};
                OFF_A_DIRECTION:  o_avs_readdata <= {24'h000000, a_dir_q};
                OFF_A_PULLUP:     o_avs_readdata <= {24'h000000, a_pu_q};
                OFF_A_ANALOG:     o_avs_readdata <= {24'h000000, a_ana_q};
                OFF_OPTION:       o_avs_readdata <= {24'h000000, option_q};
                OFF_B_PIN_DATA:   o_avs_readdata <= {24'h000000, b_in_dig};
                OFF_B_DIRECTION:  o_avs_readdata <= {24'h000000, b_dir_q};
                OFF_B_PULLUP:     o_avs_readdata <= {24'h000000, b_pu_q};
                OFF_B_ANALOG:     o_avs_readdata <= {24'h000000, b_ana_q};
                OFF_B_CHANGE_IRQ: o_avs_readdata <= {24'h000000, b_irq_q};
                default:          o_avs_readdata <= UNMAPPED_DATA;
            endcase
        end
    end

    // Pad drive, one generate per pin
    logic [7:0] a_drv_val, a_drv_oe, b_drv_val, b_drv_oe;
    logic [7:0] a_pu_d, b_pu_d;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pin
            logic a_val, b_val;
            assign a_val = i_a_periph_en[gi] ? i_a_periph_out[gi] : a_latch_q[gi];
            assign b_val = i_b_periph_en[gi] ? i_b_periph_out[gi] : b_latch_q[gi];
            if (gi == A_OPENDRAIN_BIT)
            begin : g_a_od
                assign a_drv_val[gi] = 1'b0;
                assign a_drv_oe[gi]  = !a_dir_q[gi] && !a_val;
            end
            else
            begin : g_a_pp
                assign a_drv_val[gi] = a_val;
                assign a_drv_oe[gi]  = !a_dir_q[gi] && A_DIR_MASK[gi];
            end
            if (gi == B_OPENDRAIN_BIT)
            begin : g_b_od
                assign b_drv_val[gi] = 1'b0;
                assign b_drv_oe[gi]  = !b_dir_q[gi] && !b_val;
            end
            else
            begin : g_b_pp
                assign b_drv_val[gi] = b_val;
                assign b_drv_oe[gi]  = !b_dir_q[gi] && B_DATA_MASK[gi];
            end
            if (gi == A_INPUT_ONLY_BIT)
            begin : g_a_master_clear_input
                assign a_pu_d[gi] = i_master_clear_input_en ||
                    (option_q[GLOBAL_PU_BIT] == 1'b0 && a_dir_q[gi] && a_pu_q[gi]);
            end
            else
            begin : g_a_pu
                assign a_pu_d[gi] = option_q[GLOBAL_PU_BIT] == 1'b0 && a_dir_q[gi]
                                    && a_pu_q[gi] && !a_ana_q[gi];
            end
            assign b_pu_d[gi] = option_q[GLOBAL_PU_BIT] == 1'b0 && b_dir_q[gi]
                                && b_pu_q[gi] && !b_ana_q[gi];
        end
    endgenerate

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_a_pin    <= 8'h00;
            o_a_pin_oe <= 8'h00;
            o_b_pin    <= 8'h00;
            o_b_pin_oe <= 8'h00;
            o_a_pullup <= 8'h00;
            o_b_pullup <= 8'h00;
        end
        else
        begin
            o_a_pin    <= a_drv_val;
            o_a_pin_oe <= a_drv_oe;
            o_b_pin    <= b_drv_val;
            o_b_pin_oe <= b_drv_oe;
            o_a_pullup <= a_pu_d;
            o_b_pullup <= b_pu_d;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_a_analog_mode   <= 8'h00;
            o_b_analog_mode   <= 8'h00;
            o_b_change_irq_en <= 8'h00;
        end
        else
        begin
            o_a_analog_mode   <= a_ana_q;
            o_b_analog_mode   <= b_ana_q;
            o_b_change_irq_en <= b_irq_q & ~b_ana_q;
        end
    end

    // Checks: bus handshake
    chk_wait_one: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("wait not one cycle");
    chk_wait_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !i_avs_read && !i_avs_write |=> o_avs_waitrequest)
        else $error("waitrequest low while idle");
    chk_write_on_accept: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_avs_write && o_avs_waitrequest |=> $stable(a_latch_q) && $stable(a_dir_q))
        else $error("write landed before accept");
    chk_read_upper: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_avs_readdata[31:8] == 24'h000000)
        else $error("readdata upper bits set");

    // Checks: register contents
    chk_pin5_dir_one: assert property (@(posedge i_core_clk) disable iff (i_rst)
        a_dir_q[A_INPUT_ONLY_BIT] == 1'b1)
        else $error("pin5 direction not one");
    chk_unimpl_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (a_dir_q[4] == 1'b0) && ((a_pu_q & ~A_PULLUP_MASK) == 8'h00)
        && ((a_ana_q & ~A_ANALOG_MASK) == 8'h00)) else $error("unimplemented bit set");
    chk_b_unimpl: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ((b_dir_q & ~B_DATA_MASK) == 8'h00) && ((b_pu_q & ~B_PULLUP_MASK) == 8'h00)
        && ((b_irq_q & ~B_IRQ_MASK) == 8'h00)) else $error("port b unused bit set");
    chk_latch_masked: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ((a_latch_q & ~A_DATA_MASK) == 8'h00) && ((b_latch_q & ~B_DATA_MASK) == 8'h00))
        else $error("latch unused bit set");

    // Checks: pad drive
    chk_dir_driver: assert property (@(posedge i_core_clk) disable iff (i_rst)
        a_dir_q[0] |=> !o_a_pin_oe[0])
        else $error("input pin driven");
    chk_dir_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !a_dir_q[0] |=> o_a_pin_oe[0])
        else $error("output pin not driven");
    chk_input_only_oe: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_a_pin_oe[A_INPUT_ONLY_BIT] == 1'b0 && o_a_pin_oe[4] == 1'b0)
        else $error("input-only pin driven");
    chk_od_high: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_a_pin[A_OPENDRAIN_BIT] == 1'b0 && o_b_pin[B_OPENDRAIN_BIT] == 1'b0)
        else $error("open-drain drives high");
    chk_od_b_release: assert property (@(posedge i_core_clk) disable iff (i_rst)
        b_dir_q[B_OPENDRAIN_BIT] |=> !o_b_pin_oe[B_OPENDRAIN_BIT])
        else $error("open-drain input pin driven");
    chk_periph_take: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_a_periph_en[0] && !a_dir_q[0] |=> o_a_pin[0] == $past(i_a_periph_out[0]))
        else $error("peripheral lost its pin");
    chk_analog_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !b_dir_q[1] && b_ana_q[1] |=> o_b_pin_oe[1])
        else $error("analog select stopped drive");
    chk_latch_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !a_dir_q[2] && !i_a_periph_en[2] |=> o_a_pin[2] == $past(a_latch_q[2]))
        else $error("latch not on pin");

    // Checks: pull-ups
    chk_pullup_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
        option_q[GLOBAL_PU_BIT] && !i_master_clear_input_en |=> o_a_pullup == 8'h00)
        else $error("pull-up without global enable");
    chk_pu_global_b: assert property (@(posedge i_core_clk) disable iff (i_rst)
        option_q[GLOBAL_PU_BIT] |=> o_b_pullup == 8'h00)
        else $error("port b pull-up without global enable");
    chk_master_clear_input_pullup: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_master_clear_input_en |=> o_a_pullup[A_INPUT_ONLY_BIT])
        else $error("master clear pull-up off");
    chk_a_pu_analog: assert property (@(posedge i_core_clk) disable iff (i_rst)
        a_ana_q[0] |=> !o_a_pullup[0])
        else $error("pull-up on analog pin");
    chk_b_pu_output: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !b_dir_q[7] |=> !o_b_pullup[7])
        else $error("pull-up on output pin");
    chk_b_pu_analog: assert property (@(posedge i_core_clk) disable iff (i_rst)
        b_ana_q[1] |=> !o_b_pullup[1])
        else $error("port b pull-up on analog pin");

    // Checks: analog reads and change enables
    chk_analog_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_avs_read && !ack_q && i_avs_address == OFF_A_PIN_DATA && a_ana_q[0]
        |=> o_avs_readdata[0] == 1'b0) else $error("analog pin read one");
    chk_irq_analog: assert property (@(posedge i_core_clk) disable iff (i_rst)
        b_ana_q[1] |=> !o_b_change_irq_en[1])
        else $error("irq on analog pin");
    chk_irq_mask: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (o_b_change_irq_en & ~B_IRQ_MASK) == 8'h00)
        else $error("change enable on unused bit");

    // Coverage of the main scenarios
    cov_latch_write: cover property (@(posedge i_core_clk)
        wr_hit && i_avs_address == OFF_A_PIN_DATA);
    cov_periph_take: cover property (@(posedge i_core_clk) i_a_periph_en[1] && !a_dir_q[1]);
    cov_pullup_on: cover property (@(posedge i_core_clk) o_b_pullup != 8'h00);
    cov_analog_read: cover property (@(posedge i_core_clk)
        i_avs_read && !ack_q && i_avs_address == OFF_B_PIN_DATA && b_ana_q[1]);
    cov_master_clear_input_pullup: cover property (@(posedge i_core_clk)
        i_master_clear_input_en && o_a_pullup[A_INPUT_ONLY_BIT]);
endmodule : dual_gpio_port_control
`default_nettype wire

// File: testbench/gpio_board_model.sv
// Board model for the GPIO pads: driver, external source, pull-up.
// Assumes drive enables are high while the block drives a pad.
`timescale 1ns/1ps
`default_nettype none
module gpio_board_model
(
    // Clock
    input  wire logic       i_core_clk,
    // Block side of the pads
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pullup,
    // External sources
    input  wire logic [7:0] i_ext_en,
    input  wire logic [7:0] i_ext_val,
    // Pad levels back to the block
    output logic      [7:0] o_pin
);
    logic [7:0] float_q = 8'h55;

    // Undriven pad wanders every cycle
    always_ff @(posedge i_core_clk)
    begin
        float_q <= ~float_q;
    end

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            o_pin[i] = i_oe[i] ? i_out[i] : i_ext_en[i] ? i_ext_val[i] :
                       i_pullup[i] ? 1'b1 : float_q[i];
        end
    end
endmodule : gpio_board_model
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the dual GPIO port block.
// Assumes board models on both ports and the package register map.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gpio_port_pkg::*;
    logic              clk   = 1'b0;
    logic              rst   = 1'b1;
    logic [ADDR_W-1:0] adr   = '0;
    logic              rd    = 1'b0;
    logic              wr    = 1'b0;
    logic [DATA_W-1:0] wdat  = '0;
    logic [3:0]        be    = 4'hf;
    logic              master_clear_input  = 1'b0;
    logic [7:0]        a_pen = 8'h00;
    logic [7:0]        a_po  = 8'h00;
    logic [7:0]        b_pen = 8'h00;
    logic [7:0]        b_po  = 8'h00;
    logic [7:0]        xen   = 8'hff;
    logic [DATA_W-1:0] rdat;
    logic              wreq;
    logic [7:0]        a_pin, a_out, a_oe, a_pu, b_pin, b_out, b_oe, b_pu, a_an, b_an, b_irq;
    int                err_count = 0;
    int                n_tests   = 0;
    logic [5:0] offs [8] = '{OFF_A_DIRECTION, OFF_A_PULLUP, OFF_A_ANALOG, OFF_OPTION,
                             OFF_B_DIRECTION, OFF_B_PULLUP, OFF_B_ANALOG, OFF_B_CHANGE_IRQ};
    logic [7:0] rstv [8] = '{8'hef, 8'h2f, 8'h0f, 8'hff, 8'hf3, 8'hf2, 8'hf2, 8'h00};
    logic [7:0] msk  [8] = '{8'hcf, 8'h2f, 8'h0f, 8'hff, 8'hf3, 8'hf2, 8'hf2, 8'hf7};

    always #2 clk = ~clk;

    dual_gpio_port_control u_dut (.i_core_clk(clk), .i_rst(rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_master_clear_input_en(master_clear_input),
        .i_a_periph_en(a_pen), .i_a_periph_out(a_po), .i_b_periph_en(b_pen),
        .i_b_periph_out(b_po), .i_a_pin(a_pin), .o_a_pin(a_out), .o_a_pin_oe(a_oe),
        .o_a_pullup(a_pu), .i_b_pin(b_pin), .o_b_pin(b_out), .o_b_pin_oe(b_oe),
        .o_b_pullup(b_pu), .o_a_analog_mode(a_an), .o_b_analog_mode(b_an),
        .o_b_change_irq_en(b_irq));
    gpio_board_model u_brd_a (.i_core_clk(clk), .i_out(a_out), .i_oe(a_oe), .i_pullup(a_pu),
        .i_ext_en(xen), .i_ext_val(8'hff), .o_pin(a_pin));
    gpio_board_model u_brd_b (.i_core_clk(clk), .i_out(b_out), .i_oe(b_oe), .i_pullup(b_pu),
        .i_ext_en(xen), .i_ext_val(8'hff), .o_pin(b_pin));

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] v,
                       output logic [31:0] d);
        @(posedge clk);
        adr  <= a;
        rd   <= !w;
        wr   <= w;
        wdat <= {24'h0, v};
        do
            @(posedge clk);
        while (wreq !== 1'b0);
        d = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic wreg(input logic [5:0] a, input logic [7:0] v);
        logic [31:0] d;
        bus(1'b1, a, v, d);
    endtask : wreg

    task automatic rchk(input string nm, input logic [5:0] a, input logic [7:0] e);
        logic [31:0] d;
        bus(1'b0, a, 8'h00, d);
        chk(nm, e, d[7:0]);
    endtask : rchk

    // Pads follow one cycle after the register
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (offs[i])
            rchk("reset value", offs[i], rstv[i]);
        settle();
        chk("a pullup", 8'h00, a_pu);
        chk("b pullup", 8'h00, b_pu);
        chk("irq enable", 8'h00, b_irq);
        chk("a analog", 8'h0f, a_an);
        $display("test reset done");
        foreach (offs[i])
        begin
            wreg(offs[i], 8'hff);
            rchk("write ones", offs[i], msk[i] | ((i == 0) ? 8'h20 : 8'h00));
            wreg(offs[i], 8'h00);
            rchk("write zeros", offs[i], (i == 0) ? 8'h20 : 8'h00);
        end
        wreg(6'h28, 8'hff);
        rchk("unmapped", 6'h28, 8'h00);
        be <= 4'h0;
        wreg(OFF_B_CHANGE_IRQ, 8'hff);
        be <= 4'hf;
        rchk("no lane write", OFF_B_CHANGE_IRQ, 8'h00);
        $display("test registers done");
        wreg(OFF_A_DIRECTION, 8'hff);
        wreg(OFF_A_PULLUP, 8'hff);
        wreg(OFF_A_ANALOG, 8'h05);
        settle();
        chk("a pullup analog", 8'h2a, a_pu);
        wreg(OFF_A_DIRECTION, 8'hfd);
        settle();
        chk("a pullup output", 8'h28, a_pu);
        wreg(OFF_OPTION, 8'h80);
        settle();
        chk("a pullup global", 8'h00, a_pu);
        @(posedge clk);
        master_clear_input <= 1'b1;
        settle();
        chk("a pullup master_clear_input", 8'h20, a_pu);
        @(posedge clk);
        master_clear_input <= 1'b0;
        wreg(OFF_OPTION, 8'h00);
        wreg(OFF_B_DIRECTION, 8'hff);
        wreg(OFF_B_PULLUP, 8'hff);
        wreg(OFF_B_ANALOG, 8'h02);
        settle();
        chk("b pullup analog", 8'hf0, b_pu);
        wreg(OFF_B_ANALOG, 8'h00);
        wreg(OFF_B_DIRECTION, 8'h0f);
        settle();
        chk("b pullup output", 8'h02, b_pu);
        $display("test pullups done");
        wreg(OFF_A_DIRECTION, 8'h00);
        wreg(OFF_A_PIN_DATA, 8'h45);
        settle();
        chk("a drive enable", 8'hcf, a_oe & 8'hef);
        chk("a drive level", 8'h45, a_out & 8'hcf);
        rchk("a pin read", OFF_A_PIN_DATA, 8'h60);
        wreg(OFF_A_PIN_DATA, 8'hc5);
        settle();
        chk("a open drain", 8'h4f, a_oe & 8'hef);
        @(posedge clk);
        a_pen <= 8'h41;
        settle();
        chk("a periph", 8'h04, a_out & 8'h4f);
        wreg(OFF_A_DIRECTION, 8'hff);
        settle();
        chk("a released", 8'h00, a_oe & 8'hef);
        wreg(OFF_B_DIRECTION, 8'h00);
        wreg(OFF_B_PIN_DATA, 8'hf3);
        settle();
        chk("b drive level", 8'hf2, b_out & 8'hf2);
        chk("b drive enable", 8'hf2, b_oe & 8'hf3);
        rchk("b pin read", OFF_B_PIN_DATA, 8'hf3);
        wreg(OFF_B_ANALOG, 8'hf2);
        rchk("b analog read", OFF_B_PIN_DATA, 8'h01);
        @(negedge clk);
        chk("b analog drive", 8'hf2, b_out & 8'hf2);
        @(posedge clk);
        b_pen <= 8'h02;
        settle();
        chk("b dac takes pin", 8'hf0, b_out & 8'hf2);
        wreg(OFF_B_CHANGE_IRQ, 8'hff);
        settle();
        chk("irq enable set", 8'h05, b_irq);
        rchk("irq register", OFF_B_CHANGE_IRQ, 8'hf7);
        chk("b analog mode", 8'hf2, b_an);
        $display("test pins done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk("irq after reset", 8'h00, b_irq);
        chk("pullup after reset", 8'h00, b_pu);
        $display("test second reset done");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
